// File: bench/pmc_asserts.sv
// port assertions for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pmc_asserts
#(
  parameter [11:0] DEBOUNCE_CYCLES = 12'd1024
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic reset_pin,
  input wire logic irq_pending,
  input wire logic cpu_clk_en_ff,
  input wire logic osc_en_ff,
  input wire logic sys_reset_ff,
  input wire logic latch_strobe_ff,
  input wire logic program_store_strobe_ff,
  input wire logic [1:0] wake_source_ff
);
  // accepted write to power_control from the running state
  wire acc = psel && penable && pready_ff;
  wire wr_pc = acc && pwrite && pstrb[0] && paddr[9:2] == 8'h87 && cpu_clk_en_ff
    && !sys_reset_ff && !reset_pin;
  // settle cycles counted, since a repetition cannot span the count
  wire settle = osc_en_ff && !cpu_clk_en_ff && !latch_strobe_ff;
  logic [11:0] cnt_ff;
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      cnt_ff <= 12'h000;
    else
      cnt_ff <= settle ? cnt_ff + 12'h001 : 12'h000;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_idle; wr_pc && pwdata[1:0] == 2'b01
    |=> !cpu_clk_en_ff && osc_en_ff && latch_strobe_ff; endproperty
  a_idle: assert property (p_idle) else $error("idle entry wrong");
  property p_pdown; wr_pc && pwdata[1] |=> !osc_en_ff && !cpu_clk_en_ff; endproperty
  a_pdown: assert property (p_pdown) else $error("power-down entry wrong");
  property p_strobe; !osc_en_ff |-> !latch_strobe_ff && !program_store_strobe_ff; endproperty
  a_strobe: assert property (p_strobe) else $error("strobes not low");
  property p_wake; !cpu_clk_en_ff && latch_strobe_ff && irq_pending |=> cpu_clk_en_ff; endproperty
  a_wake: assert property (p_wake) else $error("idle not ended");
  property p_rd0; acc && !pwrite && paddr[9:2] == 8'h87 |-> prdata_ff[1:0] == 2'b00; endproperty
  a_rd0: assert property (p_rd0) else $error("mode bits read nonzero");
  property p_settle; $rose(cpu_clk_en_ff) && wake_source_ff != 2'b00
    |-> cnt_ff == DEBOUNCE_CYCLES; endproperty
  a_settle: assert property (p_settle) else $error("settle length wrong");
  property p_rpin; reset_pin [*4] |-> sys_reset_ff && cpu_clk_en_ff && osc_en_ff; endproperty
  a_rpin: assert property (p_rpin) else $error("reset pin ignored");
  property p_err; acc && !(paddr[9:2] inside {8'h87, 8'ha8, 8'hbf, 8'hf0}) |-> pslverr_ff;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access accepted");
  // main scenarios reached
  c_idle: cover property (wr_pc && pwdata[1:0] == 2'b01);
  c_wake: cover property ($rose(cpu_clk_en_ff) && wake_source_ff != 2'b00);
  c_err: cover property (acc && pslverr_ff);
endmodule
bind pmc_power_mode_controller pmc_asserts #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
  pmc_asserts_inst (.*);
`default_nettype wire

// File: bench/pmc_far_model.sv
// far side: core strobes, wake pins and the reset pin
`timescale 1ns/1ps
`default_nettype none
module pmc_far_model
#(
  parameter int HOLD_CYCLES = 250000
)
(
  input wire logic clk,
  output logic reset_pin,
  output logic ext_irq_pin_a_n,
  output logic ext_irq_pin_b_n,
  output logic irq_pending,
  output logic ext_code_mem_pin,
  output logic cpu_latch_strobe,
  output logic cpu_program_store_strobe
);
  // pins idle inactive; external program memory in use
  initial
  begin
    {reset_pin, ext_irq_pin_a_n, ext_irq_pin_b_n, irq_pending} = 4'h6;
    ext_code_mem_pin = 1'b1;
  end
  // strobes toggle so that a stuck copy shows up; one process owns them
  initial
  begin
    {cpu_latch_strobe, cpu_program_store_strobe} = 2'h1;
    forever
    begin
      @(posedge clk);
      {cpu_latch_strobe, cpu_program_store_strobe} <=
        ~{cpu_latch_strobe, cpu_program_store_strobe};
    end
  end
  // external program memory on or off, changed just after an edge
  task code_mem(input logic v);
    @(posedge clk);
    ext_code_mem_pin <= v;
  endtask
  // pin levels change just after an edge
  task pins(input logic [3:0] v);
    @(posedge clk);
    {reset_pin, ext_irq_pin_a_n, ext_irq_pin_b_n, irq_pending} <= v;
  endtask
  // reset pin held long enough for the oscillator to settle
  task reset_wake;
    pins(4'he);
    repeat (HOLD_CYCLES) @(posedge clk);
    pins(4'h6);
  endtask
endmodule
`default_nettype wire

// File: bench/pmc_power_mode_controller_test.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller_test;
  localparam logic [11:0] DB = 12'd4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic watchdog_reset_flag = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h1;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, reset_pin, ext_irq_pin_a_n, ext_irq_pin_b_n, irq_pending;
  logic ext_code_mem_pin, cpu_latch_strobe, cpu_program_store_strobe, sys_reset_ff;
  logic cpu_clk_en_ff, periph_clk_en_ff, osc_en_ff, latch_strobe_ff, program_store_strobe_ff;
  logic port0_float_ff, port2_address_ff, port_hold_ff, baud_doubler_ff, err;
  logic [1:0] wake_source_ff;
  logic [7:0] rd;
  int n_mismatch = 0;
  int n_tests = 0;
  // outputs packed so one compare covers a whole mode
  wire [7:0] mode = {cpu_clk_en_ff, periph_clk_en_ff, osc_en_ff, latch_strobe_ff,
    program_store_strobe_ff, port0_float_ff, port2_address_ff, port_hold_ff};
  wire [7:0] misc = {4'h0, sys_reset_ff, baud_doubler_ff, wake_source_ff};
  pmc_power_mode_controller #(.DEBOUNCE_CYCLES(DB)) pmc_power_mode_controller_inst (.*);
  pmc_far_model #(.HOLD_CYCLES(20)) far (.*);
  // 25 mhz clock
  always #20 clk = ~clk;
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready_ff !== 1'b1)
      @(posedge clk);
    rd = prdata_ff[7:0];
    err = pslverr_ff;
    {psel, penable} <= 2'b00;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  // two edges let the last change land first
  task chkm(input logic [7:0] mask, input logic [7:0] exp);
    repeat (2) @(posedge clk);
    chk(mode & mask, exp);
  endtask
  task give_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // register defaults, flags, idle and power-down exits
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdc(8'h87, 8'h00);
    rdc(8'ha8, 8'h00);
    rdc(8'hbf, 8'h82);
    watchdog_reset_flag <= 1'b0;
    rdc(8'hbf, 8'h02);
    watchdog_reset_flag <= 1'b1;
    apb(1'b0, 8'h10, 8'h00);
    chk({7'h0, err}, 8'h01);
    apb(1'b1, 8'h87, 8'h8c);
    rdc(8'h87, 8'h8c);
    chk(misc, 8'h04);
    // a write with its low byte lane off must leave the register alone
    pstrb <= 4'h0;
    apb(1'b1, 8'h87, 8'h00);
    pstrb <= 4'h1;
    rdc(8'h87, 8'h8c);
    apb(1'b1, 8'h87, 8'h8d);
    chkm(8'hff, 8'h7f);
    far.pins(4'h7);
    chkm(8'he7, 8'he0);
    far.pins(4'h6);
    rdc(8'h87, 8'h8c);
    // internal program memory: port 0 and port 2 keep data in idle
    far.code_mem(1'b0);
    apb(1'b1, 8'h87, 8'h01);
    chkm(8'hff, 8'h79);
    far.pins(4'he);
    repeat (4) @(posedge clk);
    chk(misc, 8'h08);
    far.pins(4'h6);
    far.code_mem(1'b1);
    repeat (4) @(posedge clk);
    rdc(8'h87, 8'h00);
    // wake enable off: pin a must not wake
    apb(1'b1, 8'ha8, 8'h81);
    apb(1'b1, 8'h87, 8'h0e);
    chkm(8'hff, 8'h05);
    rdc(8'hf0, 8'h02);
    far.pins(4'h2);
    repeat (6) @(posedge clk);
    chk(mode, 8'h05);
    far.pins(4'h6);
    apb(1'b1, 8'h87, 8'h80);
    rdc(8'h87, 8'h0c);
    far.reset_wake();
    repeat (4) @(posedge clk);
    chk(mode & 8'he7, 8'he0);
    rdc(8'h87, 8'h00);
    // pin b wakes, pin a is not enabled
    apb(1'b1, 8'hbf, 8'h12);
    apb(1'b1, 8'ha8, 8'h84);
    rdc(8'hbf, 8'h92);
    apb(1'b1, 8'h87, 8'h8f);
    chkm(8'hff, 8'h05);
    far.pins(4'h2);
    repeat (6) @(posedge clk);
    chk(mode, 8'h05);
    // clock enable low freezes the synchronisers, so the pin cannot wake yet
    ce <= 1'b0;
    far.pins(4'h4);
    repeat (6) @(posedge clk);
    chk(mode, 8'h05);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    chk(mode & 8'h80, 8'h00);
    repeat (DB + 4) @(posedge clk);
    chk(misc, 8'h06);
    rdc(8'hf0, 8'h10);
    chk(mode & 8'he7, 8'he0);
    far.pins(4'h6);
    rdc(8'h87, 8'h8c);
    give_verdict();
  end
  // a hang counts as a mismatch
  initial
  begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire

// File: src/pmc_map.vh
// register indices, field positions, reset values and timing counts of the power mode controller
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// register indices; the apb byte address is four times the index
`define PMC_IDX_POWER_CONTROL 8'h87
`define PMC_IDX_IRQ_ENABLE 8'ha8
`define PMC_IDX_SYSTEM_CONTROL 8'hbf
`define PMC_IDX_MODE_STATUS 8'hf0

// reset values
`define PMC_POWER_CONTROL_RST 8'h00
`define PMC_IRQ_ENABLE_RST 8'h00
`define PMC_SYSTEM_CONTROL_RST 8'h02

// power_control fields
`define PMC_PC_IDLE 0
`define PMC_PC_PDOWN 1
`define PMC_PC_FLAG0 2
`define PMC_PC_FLAG1 3
`define PMC_PC_BAUD 7
`define PMC_PC_RW_MASK 8'h8c

// system_control fields
`define PMC_SC_LATCH_INH 0
`define PMC_SC_EXTRA_MEM 1
`define PMC_SC_ISP 2
`define PMC_SC_WAKE_EN 4
`define PMC_SC_WDT_FLAG 7
`define PMC_SC_RW_MASK 8'h17

// irq_enable fields
`define PMC_IE_A 0
`define PMC_IE_B 2
`define PMC_IE_GLOBAL 7
`define PMC_IE_RW_MASK 8'hbf

// mode_status fields
`define PMC_MS_IDLE 0
`define PMC_MS_PDOWN 1
`define PMC_MS_DEBOUNCE 2
`define PMC_MS_WAKE_LSB 3

// clock settle time after a pin wake-up, in cycles of clk
`define PMC_DEBOUNCE_CYCLES 12'd1024

`endif

// File: src/pmc_power_mode_controller.v
// idle and power-down mode controller with apb register access
//
// How it works
// - power_control bits 3 and 2 are plain read/write user flags
// - writing 1 to power_control bit 1 enters power-down; it reads 0
// - writing 1 to power_control bit 0 enters idle; it reads 0
// - idle gates the cpu clock right after the write; peripherals keep clock
// - an enabled pending interrupt ends idle and lets the cpu service it
// - after wake the cpu resumes at the instruction after the idle entry
// - reset pin high during idle raises the internal reset, ending idle
// - power-down stops the oscillator after the entering write
// - register contents stay unchanged for the whole of power-down
// - reset pin leaving power-down restarts the cpu from address zero
// - interrupt pin wake resumes into that pin's service routine
// - pin wake needs global enable, that pin's enable and wake enable
// - system_control bit 4 enables power-down wake by either interrupt pin
// - pin wake is followed by a clock settle count before the cpu runs
// - strobes 1 in idle, 0 in power-down; port 0/2 follow the mode
// - irq_enable bits 0 and 2 enable pins a and b, bit 7 global
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// offsets, fields and counts must be known before the parameter default uses them
`include "pmc_map.vh"

module pmc_power_mode_controller
#(
  parameter [11:0] DEBOUNCE_CYCLES = `PMC_DEBOUNCE_CYCLES
)
(
  input wire clk,
  input wire ce,
  input wire reset_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  // pins
  input wire reset_pin,
  input wire ext_irq_pin_a_n,
  input wire ext_irq_pin_b_n,
  input wire ext_code_mem_pin,
  // from core logic on clk
  input wire irq_pending,
  input wire cpu_latch_strobe,
  input wire cpu_program_store_strobe,
  input wire watchdog_reset_flag,
  // controls out
  output reg cpu_clk_en_ff,
  output reg periph_clk_en_ff,
  output reg osc_en_ff,
  output reg sys_reset_ff,
  output reg latch_strobe_ff,
  output reg program_store_strobe_ff,
  output reg port0_float_ff,
  output reg port2_address_ff,
  output reg port_hold_ff,
  output reg [1:0] wake_source_ff,
  output reg baud_doubler_ff
);

  // one-hot mode states
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_PDOWN = 4'h4;
  localparam [3:0] ST_SETTLE = 4'h8;

  reg [3:0] mode_ff;
  reg [3:0] nxt_mode;
  reg [11:0] cnt_ff;
  reg [11:0] nxt_cnt;
  reg [1:0] nxt_wake;
  reg [7:0] power_control_ff;
  reg [7:0] irq_enable_ff;
  reg [7:0] system_control_ff;
  reg [31:0] rd_data;
  reg rd_hit;

  wire rst_pin_s;
  wire irq_a_n_s;
  wire irq_b_n_s;
  wire ext_code_s;
  wire [7:0] idx;
  wire setup;
  wire wr_en;
  wire pc_wr;
  wire wake_a;
  wire wake_b;

  // every pin passes two flops before use
  pmc_sync #(.RST_VAL(1'b0)) u_sync_rst
  (
    .clk(clk),
    .ce(ce),
    .reset_n(reset_n),
    .d(reset_pin),
    .q_ff(rst_pin_s)
  );

  pmc_sync #(.RST_VAL(1'b1)) u_sync_irq_a
  (
    .clk(clk),
    .ce(ce),
    .reset_n(reset_n),
    .d(ext_irq_pin_a_n),
    .q_ff(irq_a_n_s)
  );

  pmc_sync #(.RST_VAL(1'b1)) u_sync_irq_b
  (
    .clk(clk),
    .ce(ce),
    .reset_n(reset_n),
    .d(ext_irq_pin_b_n),
    .q_ff(irq_b_n_s)
  );

  pmc_sync #(.RST_VAL(1'b0)) u_sync_code
  (
    .clk(clk),
    .ce(ce),
    .reset_n(reset_n),
    .d(ext_code_mem_pin),
    .q_ff(ext_code_s)
  );

  // apb decode; a write lands at the access edge where pready is seen high
  assign idx = paddr[9:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_ff && pwrite && pstrb[0] && !pslverr_ff;
  assign pc_wr = wr_en && (idx == `PMC_IDX_POWER_CONTROL);

  // pin wake needs all three enables; pins are active low
  assign wake_a = !irq_a_n_s && irq_enable_ff[`PMC_IE_GLOBAL] && irq_enable_ff[`PMC_IE_A]
    && system_control_ff[`PMC_SC_WAKE_EN];
  assign wake_b = !irq_b_n_s && irq_enable_ff[`PMC_IE_GLOBAL] && irq_enable_ff[`PMC_IE_B]
    && system_control_ff[`PMC_SC_WAKE_EN];

  // read mux; mode bits of power_control are never stored so read 0
  always @*
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (idx)
      `PMC_IDX_POWER_CONTROL:
        rd_data[7:0] = power_control_ff;
      `PMC_IDX_IRQ_ENABLE:
        rd_data[7:0] = irq_enable_ff;
      `PMC_IDX_SYSTEM_CONTROL:
        rd_data[7:0] = {watchdog_reset_flag, system_control_ff[6:0]};
      `PMC_IDX_MODE_STATUS:
      begin
        rd_data[`PMC_MS_IDLE] = mode_ff[1];
        rd_data[`PMC_MS_PDOWN] = mode_ff[2];
        rd_data[`PMC_MS_DEBOUNCE] = mode_ff[3];
        rd_data[`PMC_MS_WAKE_LSB+1:`PMC_MS_WAKE_LSB] = wake_source_ff;
      end
      default:
        rd_hit = 1'b0;
    endcase
  end

  // mode sequencing
  always @*
  begin
    nxt_mode = mode_ff;
    nxt_cnt = cnt_ff;
    nxt_wake = wake_source_ff;
    case (mode_ff)
      ST_RUN:
      begin
        // power-down wins when both bits are written at once
        if (pc_wr && pwdata[`PMC_PC_PDOWN])
        begin
          nxt_mode = ST_PDOWN;
          nxt_wake = 2'h0;
        end
        else if (pc_wr && pwdata[`PMC_PC_IDLE])
        begin
          nxt_mode = ST_IDLE;
          nxt_wake = 2'h0;
        end
      end
      ST_IDLE:
      begin
        // the cpu state is frozen, so it picks up after the entry write
        if (irq_pending)
          nxt_mode = ST_RUN;
      end
      ST_PDOWN:
      begin
        if (wake_a || wake_b)
        begin
          nxt_mode = ST_SETTLE;
          nxt_cnt = DEBOUNCE_CYCLES;
          nxt_wake = {wake_b, wake_a};
        end
      end
      ST_SETTLE:
      begin
        // cpu stays gated until the oscillator has had time to settle
        if (cnt_ff <= 12'h001)
        begin
          nxt_mode = ST_RUN;
          nxt_cnt = 12'h000;
        end
        else
          nxt_cnt = cnt_ff - 12'h001;
      end
      default:
        nxt_mode = ST_RUN;
    endcase
    // reset pin overrides every mode and restarts the core
    if (rst_pin_s)
    begin
      nxt_mode = ST_RUN;
      nxt_cnt = 12'h000;
      nxt_wake = 2'h0;
    end
  end

  // state, registers and apb answer
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_ff <= ST_RUN;
      cnt_ff <= 12'h000;
      wake_source_ff <= 2'h0;
      power_control_ff <= `PMC_POWER_CONTROL_RST;
      irq_enable_ff <= `PMC_IRQ_ENABLE_RST;
      system_control_ff <= `PMC_SYSTEM_CONTROL_RST;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else if (ce)
    begin
      mode_ff <= nxt_mode;
      cnt_ff <= nxt_cnt;
      wake_source_ff <= nxt_wake;
      // answer one cycle after setup: zero wait states
      pready_ff <= setup;
      if (setup)
      begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_ff <= !rd_hit;
      end
      else
        pslverr_ff <= 1'b0;
      if (rst_pin_s)
      begin
        // internal hardware reset returns software state to defaults
        power_control_ff <= `PMC_POWER_CONTROL_RST;
        irq_enable_ff <= `PMC_IRQ_ENABLE_RST;
        system_control_ff <= `PMC_SYSTEM_CONTROL_RST;
      end
      else if (wr_en && !mode_ff[2] && !mode_ff[3])
      begin
        // writes are dropped while powered down so contents hold
        case (idx)
          `PMC_IDX_POWER_CONTROL:
            power_control_ff <= pwdata[7:0] & `PMC_PC_RW_MASK;
          `PMC_IDX_IRQ_ENABLE:
            irq_enable_ff <= pwdata[7:0] & `PMC_IE_RW_MASK;
          `PMC_IDX_SYSTEM_CONTROL:
            system_control_ff <= pwdata[7:0] & `PMC_SC_RW_MASK;
          default:
            power_control_ff <= power_control_ff;
        endcase
      end
    end
  end

  // clock gating and pin controls follow the next mode; reset follows the synchronised reset pin
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpu_clk_en_ff <= 1'b1;
      periph_clk_en_ff <= 1'b1;
      osc_en_ff <= 1'b1;
      sys_reset_ff <= 1'b0;
      latch_strobe_ff <= 1'b0;
      program_store_strobe_ff <= 1'b0;
      port0_float_ff <= 1'b0;
      port2_address_ff <= 1'b0;
      port_hold_ff <= 1'b0;
      baud_doubler_ff <= 1'b0;
    end
    else if (ce)
    begin
      // cpu gated from the edge that takes the entry write
      cpu_clk_en_ff <= nxt_mode[0];
      periph_clk_en_ff <= nxt_mode[0] || nxt_mode[1];
      osc_en_ff <= !nxt_mode[2];
      sys_reset_ff <= rst_pin_s;
      baud_doubler_ff <= power_control_ff[`PMC_PC_BAUD];
      // strobes parked high in idle, low in power-down and settle
      if (nxt_mode[1])
      begin
        latch_strobe_ff <= 1'b1;
        program_store_strobe_ff <= 1'b1;
      end
      else if (nxt_mode[2] || nxt_mode[3])
      begin
        latch_strobe_ff <= 1'b0;
        program_store_strobe_ff <= 1'b0;
      end
      else
      begin
        latch_strobe_ff <= cpu_latch_strobe && !system_control_ff[`PMC_SC_LATCH_INH];
        program_store_strobe_ff <= cpu_program_store_strobe;
      end
      // external code: port 0 floats whenever the cpu clock is gated, port 2 keeps address only in idle
      port0_float_ff <= ext_code_s && !nxt_mode[0];
      port2_address_ff <= ext_code_s && nxt_mode[1];
      port_hold_ff <= !nxt_mode[0];
    end
  end

endmodule

`default_nettype wire

// File: src/pmc_sync.v
// two-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none

module pmc_sync
#(
  parameter RST_VAL = 1'b0
)
(
  input wire clk,
  input wire ce,
  input wire reset_n,
  input wire d,
  output reg q_ff
);

  reg meta_ff;

  // first flop feeds only the second one
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end
    else if (ce)
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

endmodule

`default_nettype wire
